// ---- bench/oas_mem_model.sv ----
// program and data memory answering the block's bus
`timescale 1ns/100ps
module oas_mem_model (
    input wire logic i_clock,
    input wire oas_pkg::oas_bus_t i_bus,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last;
    // a released bus shows the inverse of the last byte, so a late sample never matches by luck
    assign o_rdata = i_bus.rd ? mem[i_bus.addr] : ~last;
    initial begin
        last = 8'h00;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    always @(posedge i_clock) begin
        if (i_bus.rd === 1'b1) begin
            last <= mem[i_bus.addr];
        end
        if (i_bus.wr === 1'b1) begin
            mem[i_bus.addr] <= i_bus.wdata;
        end
    end
endmodule

// ---- bench/oas_top_bench.sv ----
// self-checking bench of the addressing and sequencing block
`timescale 1ns/100ps
module oas_top_bench;
    logic i_clock = 1'b0;
    logic i_rst_n, i_reset_pin_n, i_reset_busy, i_irq, i_debug_halt, i_debug_go, i_debug_enable, i_keep_min_clocks;
    logic [7:0] rdata;
    logic [15:0] i_irq_vec, i_trap_vec;
    oas_pkg::oas_op_t i_op;
    oas_pkg::oas_regs_t regs;
    logic o_ready;
    oas_pkg::oas_bus_t o_bus;
    oas_pkg::oas_result_t o_result;
    oas_pkg::oas_ctl_t o_ctl;
    oas_pkg::oas_pwr_t o_pwr;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int cyc;
    bit hxl, wr;
    always #20 i_clock = ~i_clock;
    oas_top oas_top_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reset_pin_n(i_reset_pin_n),
        .i_reset_busy(i_reset_busy), .i_op(i_op), .i_regs(regs), .i_rdata(rdata), .i_irq(i_irq),
        .i_irq_vec(i_irq_vec), .i_trap_vec(i_trap_vec), .i_debug_halt(i_debug_halt), .i_debug_go(i_debug_go),
        .i_debug_enable(i_debug_enable), .i_keep_min_clocks(i_keep_min_clocks), .o_ready(o_ready),
        .o_bus(o_bus), .o_result(o_result), .o_ctl(o_ctl), .o_pwr(o_pwr));
    oas_mem_model oas_mem_model_i (.i_clock(i_clock), .i_bus(o_bus), .o_rdata(rdata));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // the whole run needs well under a thousand cycles
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            $display("CHECK FAILED at %0t: hang", $time);
            give_verdict();
        end
    end
    task automatic chk(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(negedge i_clock);
    endtask
    function automatic logic [7:0] mb(input logic [15:0] a);
        return oas_mem_model_i.mem[a];
    endfunction
    task automatic put16(input logic [15:0] a, input logic [15:0] v);
        oas_mem_model_i.mem[a] = v[15:8];
        oas_mem_model_i.mem[16'(a + 16'h0001)] = v[7:0];
    endtask
    task automatic issue(input oas_pkg::oas_kind_t k, input int m = 0);
        int n = 0;
        // an edge passes first, so a valid just lowered is never raised in the same step
        tick();
        while (o_ready !== 1'b1 && n < 30) begin
            tick();
            n++;
        end
        chk(o_ready === 1'b1, "not ready");
        i_op = '{valid: 1'b1, kind: k, mode: oas_pkg::oas_mode_t'(m)};
        tick();
        i_op.valid = 1'b0;
    endtask
    task automatic do_op(input int m);
        hxl = 0;
        wr = 0;
        cyc = 1;
        issue(oas_pkg::K_ADDR, m);
        while (o_result.done !== 1'b1 && cyc < 12) begin
            wr |= (o_bus.wr === 1'b1);
            tick();
            cyc++;
        end
        hxl = (o_result.hx_load === 1'b1);
    endtask
    task automatic entry_check(input logic [15:0] vec, input logic [15:0] tgt);
        logic [7:0] d [5];
        int n = 0;
        d = '{regs.pc[7:0], regs.pc[15:8], regs.hx[7:0], regs.a, regs.condition_code_register};
        put16(vec, tgt);
        while (o_bus.wr !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        // the request vector moves on; the latched one must still be used
        i_irq_vec = ~vec;
        for (int i = 0; i < 5; i++) begin
            chk(o_bus.wr === 1'b1 && o_bus.addr === 16'(regs.sp - i) && o_bus.wdata === d[i], "push");
            tick();
        end
        chk(o_bus.wr === 1'b0 && o_ctl.set_imask === 1'b1 && o_ctl.sp_next === 16'(regs.sp - 5), "mask");
        // the cpu now holds its mask set, so a still pending request is not taken again
        regs.condition_code_register = regs.condition_code_register | 8'h08;
        chk(o_ctl.sp_load === 1'b1 && o_bus.rd === 1'b1 && o_bus.addr === vec, "vector high");
        tick();
        chk(o_bus.rd === 1'b1 && o_bus.addr === 16'(vec + 1), "vector low");
        tick();
        chk(o_bus.rd === 1'b0 && o_bus.wr === 1'b0, "free cycle");
        for (int i = 0; i < 4; i++) begin
            tick();
            if (i < 3) chk(o_bus.rd === 1'b1 && o_bus.addr === 16'(tgt + i), "queue fetch");
            if (i > 0) chk(o_ctl.q_valid === 1'b1 && o_ctl.q_data === mb(16'(tgt + i - 1)), "queue");
        end
        chk(o_ctl.pc_load === 1'b1 && o_ctl.pc_next === 16'(tgt + 3), "entry target");
        tick();
    endtask
    task automatic reset_seq(input int busy);
        int n = 0;
        i_rst_n = 1'b0;
        i_reset_busy = 1'b1;
        put16(16'hfffe, 16'h1234);
        tick(5);
        i_rst_n = 1'b1;
        for (int i = 0; i < busy; i++) begin
            tick();
            chk(o_bus.rd === 1'b0, "early vector fetch");
        end
        i_reset_busy = 1'b0;
        while (o_bus.rd !== 1'b1 && n < 10) begin
            tick();
            n++;
        end
        chk(o_bus.addr === 16'hfffe, "reset vector high");
        tick();
        chk(o_bus.rd === 1'b1 && o_bus.addr === 16'hffff, "reset vector low");
        tick();
        chk(o_bus.rd === 1'b0, "reset free cycle");
        for (int i = 0; i < 3; i++) begin
            tick();
            chk(o_bus.rd === 1'b1 && o_bus.addr === 16'(16'h1234 + i), "reset queue");
        end
        tick();
        chk(o_ctl.pc_load === 1'b1 && o_ctl.pc_next === 16'h1237, "reset target");
    endtask
    task automatic modes_test;
        logic [15:0] ea;
        int n;
        regs = '{pc: 16'h2000, hx: 16'hffc0, sp: 16'hff80, a: 8'h11, condition_code_register: 8'h08};
        put16(16'h2000, 16'h9c40);
        for (int k = 0; k < 11; k++) begin
            n = (k inside {1, 3, 8, 10}) ? 2 : (k inside {4, 5}) ? 0 : 1;
            // sums wrap in 16 bits; hx and sp are chosen so the offsets carry out
            case (k)
                0: ea = 16'h2001 + 16'hff9c;
                2: ea = 16'h009c;
                1, 3: ea = 16'h9c40;
                4, 5: ea = regs.hx;
                6, 7: ea = regs.hx + 16'h009c;
                8: ea = regs.hx + 16'h9c40;
                9: ea = regs.sp + 16'h009c;
                default: ea = regs.sp + 16'h9c40;
            endcase
            do_op(k);
            chk(o_result.done === 1'b1 && cyc == n + ((k < 2) ? 2 : 3), "answer time");
            if (k == 1) chk(o_result.data === ea, "inline operand");
            else chk(o_result.ea === ea, "address");
            if (k > 1) chk(o_result.data === {8'h00, mb(ea)}, "operand");
            chk(hxl == (k inside {5, 7}) && (!hxl || o_result.hx_next === 16'hffc1), "index step");
        end
    endtask
    task automatic debug_visit;
        i_debug_halt = 1'b1;
        tick();
        i_debug_halt = 1'b0;
        tick();
        chk(o_pwr.background === 1'b1 && o_pwr.cpu_clk_en === 1'b1, "background");
        i_debug_go = 1'b1;
        tick();
        i_debug_go = 1'b0;
    endtask
    initial begin
        {i_rst_n, i_reset_busy, i_irq, i_debug_halt, i_debug_go, i_debug_enable, i_keep_min_clocks} = '0;
        i_reset_pin_n = 1'b1;
        i_op = '0;
        regs = '0;
        i_irq_vec = 16'hffe0;
        i_trap_vec = 16'hfff0;
        @(negedge i_clock);
        reset_seq(3);
        modes_test();
        i_irq = 1'b1;
        do_op(2);
        chk(!wr, "masked irq");
        for (int i = 0; i < 4; i++) begin
            tick();
            chk(o_bus.wr === 1'b0 && o_ready === 1'b1, "masked irq idle");
        end
        issue(oas_pkg::K_CLRMASK);
        chk(o_ctl.clr_imask === 1'b1, "mask clear");
        regs.condition_code_register = 8'h00;
        do_op(4);
        chk(cyc == 3 && !wr, "op after mask clear");
        entry_check(16'hffe0, 16'h3000);
        i_irq = 1'b0;
        regs.condition_code_register = 8'h08;
        issue(oas_pkg::K_TRAP);
        entry_check(i_trap_vec, 16'h3300);
        issue(oas_pkg::K_WAIT);
        chk(o_ctl.clr_imask === 1'b1, "wait clears mask");
        tick();
        chk(o_pwr.cpu_clk_en === 1'b0 && o_ready === 1'b0, "wait clocks");
        debug_visit();
        issue(oas_pkg::K_WAIT);
        regs.condition_code_register = 8'h00;
        tick(3);
        i_irq = 1'b1;
        entry_check(i_irq_vec, 16'h3100);
        i_irq = 1'b0;
        {i_debug_enable, i_keep_min_clocks} = 2'b11;
        issue(oas_pkg::K_STOP);
        tick();
        chk(o_pwr.osc_en === 1'b1 && o_pwr.min_clk_en === 1'b1 && o_pwr.cpu_clk_en === 1'b0, "stop");
        debug_visit();
        {i_debug_enable, i_keep_min_clocks} = 2'b00;
        issue(oas_pkg::K_STOP);
        tick();
        chk(o_pwr.osc_en === 1'b0 && o_pwr.min_clk_en === 1'b0, "plain stop");
        i_debug_halt = 1'b1;
        tick();
        i_debug_halt = 1'b0;
        chk(o_pwr.background === 1'b0 && o_pwr.cpu_clk_en === 1'b0, "halt with debug disabled");
        i_irq = 1'b1;
        entry_check(i_irq_vec, 16'h3200);
        i_irq = 1'b0;
        issue(oas_pkg::K_TRAP);
        tick(2);
        i_rst_n = 1'b0;
        #1 chk(o_bus.rd === 1'b0 && o_bus.wr === 1'b0 && o_ctl === oas_pkg::oas_ctl_t'(0), "abort");
        @(negedge i_clock);
        reset_seq(0);
        give_verdict();
    end
endmodule

// ---- src/oas_consts.svh ----
// constants of the operand addressing and special sequence block
`ifndef OAS_CONSTS_SVH
`define OAS_CONSTS_SVH
`define OAS_RESET_VEC 16'hfffe
`define OAS_ZERO_PAGE 8'h00
`define OAS_INC 16'h0001
`define OAS_PUSH_LAST 3'h4
`define OAS_PUSH_COUNT 16'h0005
`define OAS_QUEUE_LAST 3'h2
`define OAS_QUEUE_BYTES 16'h0003
`define OAS_IMASK_BIT 3
`endif

// ---- src/oas_pkg.sv ----
// types of the operand addressing and special sequence block
package oas_pkg;
    typedef enum logic [3:0] {
        S_RST_HOLD, S_IDLE, S_FETCH, S_CALC, S_OPER, S_PUSH, S_VEC_HI,
        S_VEC_LO, S_FREE, S_QUEUE, S_WAIT, S_STOP, S_BGND
    } oas_state_t;
    typedef enum logic [3:0] {
        BRANCH_OFFSET_MODE, INLINE_OPERAND_MODE, ZERO_PAGE_MODE, FULL_ADDRESS_MODE,
        INDEX_PLAIN_MODE, INDEX_POST_INCREMENT_MODE, INDEX_SHORT_OFFSET_MODE,
        INDEX_SHORT_OFFSET_INCREMENT_MODE, INDEX_LONG_OFFSET_MODE,
        STACK_SHORT_OFFSET_MODE, STACK_LONG_OFFSET_MODE
    } oas_mode_t;
    typedef enum logic [2:0] {
        K_ADDR, K_TRAP, K_WAIT, K_STOP, K_CLRMASK
    } oas_kind_t;
    typedef struct packed {
        logic valid;
        oas_kind_t kind;
        oas_mode_t mode;
    } oas_op_t;
    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] hx;
        logic [15:0] sp;
        logic [7:0] a;
        logic [7:0] condition_code_register;
    } oas_regs_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } oas_bus_t;
    typedef struct packed {
        logic done;
        oas_mode_t mode;
        logic [15:0] ea;
        logic [15:0] data;
        logic [15:0] pc_next;
        logic hx_load;
        logic [15:0] hx_next;
    } oas_result_t;
    typedef struct packed {
        logic set_imask;
        logic clr_imask;
        logic sp_load;
        logic [15:0] sp_next;
        logic pc_load;
        logic [15:0] pc_next;
        logic q_valid;
        logic [7:0] q_data;
    } oas_ctl_t;
    typedef struct packed {
        logic cpu_clk_en;
        logic osc_en;
        logic min_clk_en;
        logic background;
    } oas_pwr_t;
    typedef struct packed {
        oas_state_t st;
        logic [2:0] cnt;
        oas_mode_t mode;
        logic blk;
        logic pin_s1;
        logic pin_s2;
        oas_regs_t regs;
        logic [15:0] vec;
        logic [7:0] hi;
        logic [7:0] lo;
        oas_bus_t bus;
        oas_result_t res;
        oas_ctl_t ctl;
        oas_pwr_t pwr;
    } oas_core_t;
endpackage

// ---- src/oas_top.sv ----
// operand address generation and reset, interrupt, wait and stop sequencing
// How it works
// - taken branch: sign-extended offset byte added to program counter plus one gives destination
// - inline 16-bit operand: high byte first after opcode, low byte next
// - zero-page address: implied 0x00 above the instruction's address byte
// - full-address mode: 16-bit address from next two bytes, high first
// - plain indexed: index pair is the operand address
// - post-increment indexed: address by index pair, then pair plus one
// - short-offset indexed: index pair plus unsigned byte offset
// - short-offset post-increment: pair plus byte offset, then pair plus one
// - long-offset indexed: index pair plus 16-bit offset
// - stack short offset: stack pointer plus unsigned byte offset
// - stack long offset: stack pointer plus 16-bit offset
// - i_rst_n aborts activity at once, no instruction boundary wait; i_reset_pin_n only holds the reset state
// - after reset release: six cycles, vector from 0xfffe/0xffff, fill queue
// - interrupt taken at boundary; vector latched when entry begins
// - entry pushes pc low, pc high, index low, accumulator, condition codes
// - then set mask, vector high, vector low, free cycle, three queue fetches
// - upper index byte never stacked; service code saves it itself
// - software trap runs entry whatever the interrupt mask says
// - wait clears mask, stops cpu clocks; interrupt or reset resumes
// - halt-to-debug during wait resumes clocks into background mode
// - debug enable keeps oscillator in stop; halt-to-debug enters background
// - optional minimal clock set kept running in stop for periodic wake
// - mask bit set: maskable interrupts ignored until cleared; in wait or stop any request is taken
// - no interrupt at boundary right after a mask-clearing instruction
`timescale 1ns/100ps
`include "oas_consts.svh"
module oas_top (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_reset_pin_n,
    input wire logic i_reset_busy,
    input wire oas_pkg::oas_op_t i_op,
    input wire oas_pkg::oas_regs_t i_regs,
    input wire logic [7:0] i_rdata,
    input wire logic i_irq,
    input wire logic [15:0] i_irq_vec,
    input wire logic [15:0] i_trap_vec,
    input wire logic i_debug_halt,
    input wire logic i_debug_go,
    input wire logic i_debug_enable,
    input wire logic i_keep_min_clocks,
    output logic o_ready,
    output oas_pkg::oas_bus_t o_bus,
    output oas_pkg::oas_result_t o_result,
    output oas_pkg::oas_ctl_t o_ctl,
    output oas_pkg::oas_pwr_t o_pwr
);
    oas_pkg::oas_core_t s;
    oas_pkg::oas_core_t next_s;
    logic irq_take;
    logic [2:0] nb;
    function automatic logic [2:0] nbytes(input oas_pkg::oas_mode_t m);
        case (m)
            oas_pkg::INDEX_PLAIN_MODE, oas_pkg::INDEX_POST_INCREMENT_MODE: nbytes = 3'h0;
            oas_pkg::INLINE_OPERAND_MODE, oas_pkg::FULL_ADDRESS_MODE,
            oas_pkg::INDEX_LONG_OFFSET_MODE, oas_pkg::STACK_LONG_OFFSET_MODE: nbytes = 3'h2;
            default: nbytes = 3'h1;
        endcase
    endfunction
    // all sums are 16 bits wide, so they wrap with no carry kept
    function automatic logic [15:0] ea_of(input oas_pkg::oas_core_t c);
        case (c.mode)
            oas_pkg::BRANCH_OFFSET_MODE: ea_of = c.regs.pc + `OAS_INC + {{8{c.lo[7]}}, c.lo};
            oas_pkg::ZERO_PAGE_MODE: ea_of = {`OAS_ZERO_PAGE, c.lo};
            oas_pkg::FULL_ADDRESS_MODE: ea_of = {c.hi, c.lo};
            oas_pkg::INDEX_PLAIN_MODE, oas_pkg::INDEX_POST_INCREMENT_MODE: ea_of = c.regs.hx;
            oas_pkg::INDEX_SHORT_OFFSET_MODE,
            oas_pkg::INDEX_SHORT_OFFSET_INCREMENT_MODE: ea_of = c.regs.hx + {8'h00, c.lo};
            oas_pkg::INDEX_LONG_OFFSET_MODE: ea_of = c.regs.hx + {c.hi, c.lo};
            oas_pkg::STACK_SHORT_OFFSET_MODE: ea_of = c.regs.sp + {8'h00, c.lo};
            oas_pkg::STACK_LONG_OFFSET_MODE: ea_of = c.regs.sp + {c.hi, c.lo};
            default: ea_of = c.regs.pc;
        endcase
    endfunction
    // the upper index byte is deliberately absent from the frame
    function automatic logic [7:0] push_byte(input oas_pkg::oas_regs_t r, input logic [2:0] i);
        case (i)
            3'h0: push_byte = r.pc[7:0];
            3'h1: push_byte = r.pc[15:8];
            3'h2: push_byte = r.hx[7:0];
            3'h3: push_byte = r.a;
            default: push_byte = r.condition_code_register;
        endcase
    endfunction
    assign nb = nbytes(s.mode);
    // the block flag holds off one boundary after a mask clear
    assign irq_take = i_irq && !i_regs.condition_code_register[`OAS_IMASK_BIT] && !s.blk;
    assign o_ready = (s.st == oas_pkg::S_IDLE) && !irq_take;
    assign o_bus = s.bus;
    assign o_result = s.res;
    assign o_ctl = s.ctl;
    assign o_pwr = s.pwr;
    always_comb begin
        next_s = s;
        next_s.res.done = 1'b0;
        next_s.res.hx_load = 1'b0;
        next_s.ctl.set_imask = 1'b0;
        next_s.ctl.clr_imask = 1'b0;
        next_s.ctl.sp_load = 1'b0;
        next_s.ctl.pc_load = 1'b0;
        next_s.ctl.q_valid = 1'b0;
        next_s.pin_s1 = i_reset_pin_n;
        next_s.pin_s2 = s.pin_s1;
        case (s.st)
            oas_pkg::S_RST_HOLD: begin
                if (!i_reset_busy && s.pin_s2) begin
                    next_s.st = oas_pkg::S_VEC_HI;
                    next_s.vec = `OAS_RESET_VEC;
                end
            end
            oas_pkg::S_IDLE: begin
                if (irq_take) begin
                    next_s.st = oas_pkg::S_PUSH;
                    next_s.cnt = 3'h0;
                    next_s.vec = i_irq_vec;
                    next_s.regs = i_regs;
                end else if (i_op.valid) begin
                    next_s.blk = 1'b0;
                    next_s.mode = i_op.mode;
                    next_s.regs = i_regs;
                    next_s.cnt = 3'h0;
                    case (i_op.kind)
                        oas_pkg::K_ADDR: begin
                            if (nbytes(i_op.mode) == 3'h0) begin
                                next_s.st = oas_pkg::S_CALC;
                            end else begin
                                next_s.st = oas_pkg::S_FETCH;
                            end
                        end
                        oas_pkg::K_TRAP: begin
                            next_s.st = oas_pkg::S_PUSH;
                            next_s.vec = i_trap_vec;
                        end
                        oas_pkg::K_WAIT: begin
                            next_s.st = oas_pkg::S_WAIT;
                            next_s.ctl.clr_imask = 1'b1;
                        end
                        oas_pkg::K_STOP: next_s.st = oas_pkg::S_STOP;
                        oas_pkg::K_CLRMASK: begin
                            next_s.ctl.clr_imask = 1'b1;
                            next_s.blk = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            oas_pkg::S_FETCH: begin
                if (nb == 3'h2 && s.cnt == 3'h0) begin
                    next_s.hi = i_rdata;
                end else begin
                    next_s.lo = i_rdata;
                end
                next_s.cnt = s.cnt + 3'h1;
                if (s.cnt + 3'h1 == nb) begin
                    next_s.st = oas_pkg::S_CALC;
                end
            end
            oas_pkg::S_CALC: begin
                next_s.res.mode = s.mode;
                next_s.res.ea = ea_of(s);
                next_s.res.data = {s.hi, s.lo};
                next_s.res.pc_next = s.regs.pc + {13'h0000, nb};
                if (s.mode == oas_pkg::BRANCH_OFFSET_MODE || s.mode == oas_pkg::INLINE_OPERAND_MODE) begin
                    next_s.res.done = 1'b1;
                    next_s.st = oas_pkg::S_IDLE;
                end else begin
                    next_s.st = oas_pkg::S_OPER;
                end
            end
            oas_pkg::S_OPER: begin
                next_s.res.data = {8'h00, i_rdata};
                next_s.res.done = 1'b1;
                next_s.st = oas_pkg::S_IDLE;
                if (s.mode == oas_pkg::INDEX_POST_INCREMENT_MODE ||
                    s.mode == oas_pkg::INDEX_SHORT_OFFSET_INCREMENT_MODE) begin
                    next_s.res.hx_load = 1'b1;
                    next_s.res.hx_next = s.regs.hx + `OAS_INC;
                end
            end
            oas_pkg::S_PUSH: begin
                next_s.cnt = s.cnt + 3'h1;
                if (s.cnt == `OAS_PUSH_LAST) begin
                    next_s.st = oas_pkg::S_VEC_HI;
                    next_s.ctl.sp_load = 1'b1;
                    next_s.ctl.sp_next = s.regs.sp - `OAS_PUSH_COUNT;
                    next_s.ctl.set_imask = 1'b1;
                end
            end
            oas_pkg::S_VEC_HI: begin
                next_s.hi = i_rdata;
                next_s.st = oas_pkg::S_VEC_LO;
            end
            oas_pkg::S_VEC_LO: begin
                next_s.lo = i_rdata;
                next_s.st = oas_pkg::S_FREE;
            end
            oas_pkg::S_FREE: begin
                next_s.st = oas_pkg::S_QUEUE;
                next_s.cnt = 3'h0;
            end
            oas_pkg::S_QUEUE: begin
                next_s.ctl.q_valid = 1'b1;
                next_s.ctl.q_data = i_rdata;
                next_s.cnt = s.cnt + 3'h1;
                if (s.cnt == `OAS_QUEUE_LAST) begin
                    next_s.st = oas_pkg::S_IDLE;
                    next_s.ctl.pc_load = 1'b1;
                    next_s.ctl.pc_next = {s.hi, s.lo} + `OAS_QUEUE_BYTES;
                end
            end
            oas_pkg::S_WAIT: begin
                if (i_debug_halt) begin
                    next_s.st = oas_pkg::S_BGND;
                end else if (i_irq) begin
                    next_s.st = oas_pkg::S_PUSH;
                    next_s.cnt = 3'h0;
                    next_s.vec = i_irq_vec;
                    next_s.regs = i_regs;
                end
            end
            oas_pkg::S_STOP: begin
                if (i_debug_halt && i_debug_enable) begin
                    next_s.st = oas_pkg::S_BGND;
                end else if (i_irq) begin
                    next_s.st = oas_pkg::S_PUSH;
                    next_s.cnt = 3'h0;
                    next_s.vec = i_irq_vec;
                    next_s.regs = i_regs;
                end
            end
            oas_pkg::S_BGND: begin
                if (i_debug_go) begin
                    next_s.st = oas_pkg::S_IDLE;
                end
            end
            default: next_s.st = oas_pkg::S_RST_HOLD;
        endcase
        // bus and power follow the next state so both come from flops
        next_s.bus = '0;
        case (next_s.st)
            oas_pkg::S_FETCH: begin
                next_s.bus.rd = 1'b1;
                next_s.bus.addr = next_s.regs.pc + {13'h0000, next_s.cnt};
            end
            oas_pkg::S_OPER: begin
                next_s.bus.rd = 1'b1;
                next_s.bus.addr = next_s.res.ea;
            end
            oas_pkg::S_PUSH: begin
                next_s.bus.wr = 1'b1;
                next_s.bus.addr = next_s.regs.sp - {13'h0000, next_s.cnt};
                next_s.bus.wdata = push_byte(next_s.regs, next_s.cnt);
            end
            oas_pkg::S_VEC_HI: begin
                next_s.bus.rd = 1'b1;
                next_s.bus.addr = next_s.vec;
            end
            oas_pkg::S_VEC_LO: begin
                next_s.bus.rd = 1'b1;
                next_s.bus.addr = next_s.vec + `OAS_INC;
            end
            oas_pkg::S_QUEUE: begin
                next_s.bus.rd = 1'b1;
                next_s.bus.addr = {next_s.hi, next_s.lo} + {13'h0000, next_s.cnt};
            end
            default: ;
        endcase
        next_s.pwr.cpu_clk_en = !(next_s.st == oas_pkg::S_WAIT || next_s.st == oas_pkg::S_STOP);
        next_s.pwr.osc_en = (next_s.st != oas_pkg::S_STOP) || i_debug_enable;
        next_s.pwr.min_clk_en = (next_s.st != oas_pkg::S_STOP) || i_keep_min_clocks;
        next_s.pwr.background = (next_s.st == oas_pkg::S_BGND);
    end
    // reset wins over everything with no boundary wait
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
            s.pwr.osc_en <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
    property p_zero_page;
        @(posedge i_clock) disable iff (!i_rst_n)
        s.res.done && s.res.mode == oas_pkg::ZERO_PAGE_MODE |-> s.res.ea[15:8] == `OAS_ZERO_PAGE;
    endproperty
    a_zero_page: assert property (p_zero_page) else $error("zero page address high byte not zero");
    property p_inc;
        @(posedge i_clock) disable iff (!i_rst_n)
        s.res.hx_load |-> s.res.ea == $past(s.regs.hx) + ((s.res.mode == oas_pkg::INDEX_POST_INCREMENT_MODE)
            ? 16'h0000 : {8'h00, s.lo}) && s.res.hx_next == $past(s.regs.hx) + `OAS_INC;
    endproperty
    a_inc: assert property (p_inc) else $error("post increment address or step wrong");
    property p_reset_seq;
        @(posedge i_clock) disable iff (!i_rst_n)
        $past(s.st) == oas_pkg::S_RST_HOLD && s.st == oas_pkg::S_VEC_HI |-> s.bus.addr == `OAS_RESET_VEC
            ##1 s.bus.addr == `OAS_RESET_VEC + `OAS_INC ##5 s.ctl.pc_load;
    endproperty
    a_reset_seq: assert property (p_reset_seq) else $error("reset vector sequence wrong");
    property p_push_order;
        @(posedge i_clock) disable iff (!i_rst_n)
        $rose(s.st == oas_pkg::S_PUSH) |-> s.bus.wdata == s.regs.pc[7:0] ##1 s.bus.wdata == s.regs.pc[15:8]
            ##1 s.bus.wdata == s.regs.hx[7:0] ##1 s.bus.wdata == s.regs.a ##1 s.bus.wdata == s.regs.condition_code_register;
    endproperty
    a_push_order: assert property (p_push_order) else $error("stack frame order wrong");
    property p_entry_tail;
        @(posedge i_clock) disable iff (!i_rst_n)
        s.ctl.set_imask |-> s.st == oas_pkg::S_VEC_HI ##1 s.st == oas_pkg::S_VEC_LO
            ##1 !s.bus.rd && !s.bus.wr ##1 s.bus.rd [*3] ##1 s.ctl.pc_load;
    endproperty
    a_entry_tail: assert property (p_entry_tail) else $error("entry tail sequence wrong");
    property p_masked;
        @(posedge i_clock) disable iff (!i_rst_n)
        s.st == oas_pkg::S_IDLE && (i_regs.condition_code_register[`OAS_IMASK_BIT] || s.blk)
            && !(i_op.valid && i_op.kind == oas_pkg::K_TRAP) |=> s.st != oas_pkg::S_PUSH;
    endproperty
    a_masked: assert property (p_masked) else $error("masked interrupt taken");
    property p_wait;
        @(posedge i_clock) disable iff (!i_rst_n)
        s.st == oas_pkg::S_IDLE && !irq_take && i_op.valid && i_op.kind == oas_pkg::K_WAIT
            |=> s.ctl.clr_imask && !s.pwr.cpu_clk_en;
    endproperty
    a_wait: assert property (p_wait) else $error("wait did not clear mask and stop clocks");
    property p_stop_osc;
        @(posedge i_clock) disable iff (!i_rst_n)
        s.st == oas_pkg::S_STOP && !s.pwr.osc_en |=> s.st != oas_pkg::S_BGND;
    endproperty
    a_stop_osc: assert property (p_stop_osc) else $error("background entered from stop without debug");
    property p_branch;
        @(posedge i_clock) disable iff (!i_rst_n)
        s.res.done && s.res.mode == oas_pkg::BRANCH_OFFSET_MODE |-> s.res.ea == s.res.pc_next + {{8{s.lo[7]}}, s.lo};
    endproperty
    a_branch: assert property (p_branch) else $error("branch destination wrong");
    c_reset: cover property (@(posedge i_clock) disable iff (!i_rst_n) s.st == oas_pkg::S_RST_HOLD ##1 s.st == oas_pkg::S_VEC_HI);
    c_entry: cover property (@(posedge i_clock) disable iff (!i_rst_n) s.ctl.set_imask);
    c_wake: cover property (@(posedge i_clock) disable iff (!i_rst_n) s.st == oas_pkg::S_WAIT ##1 s.st == oas_pkg::S_PUSH);
    c_bgnd: cover property (@(posedge i_clock) disable iff (!i_rst_n) s.st == oas_pkg::S_STOP ##1 s.st == oas_pkg::S_BGND);
endmodule
